// *** rtl/cts_buzzer.sv ***
// two-phase square wave buzzer generator
`timescale 1ns/1ps
module cts_buzzer
  import cts_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic        enable,
  input  wire logic        idle_level,
  input  wire logic [15:0] half1_cyc,
  input  wire logic [15:0] half2_cyc,
  input  wire logic [31:0] phase1_cyc,
  input  wire logic [31:0] phase2_cyc,
  output logic             pin,
  output logic             busy
);
  logic [1:0]  phase_r;
  logic [31:0] dur_r;
  logic [15:0] half_r;
  logic        pin_r;
  logic [15:0] half_lim;

  assign half_lim = (phase_r == 2'h1) ? half1_cyc : half2_cyc;
  assign pin      = pin_r;
  assign busy     = (phase_r != 2'h0);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_r <= 2'h0;
      dur_r   <= '0;
    end else if (phase_r == 2'h0) begin
      if (start && enable) begin
        phase_r <= 2'h1;
        dur_r   <= '0;
      end
    end else if ((dur_r + 32'h1) >= ((phase_r == 2'h1) ? phase1_cyc : phase2_cyc)) begin
      phase_r <= (phase_r == 2'h1) ? 2'h2 : 2'h0;
      dur_r   <= '0;
    end else begin
      dur_r <= dur_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      half_r <= '0;
      pin_r  <= 1'b0;
    end else if (phase_r == 2'h0) begin
      half_r <= '0;
      pin_r  <= idle_level;
    end else if ((half_r + 16'h1) >= half_lim) begin
      half_r <= '0;
      pin_r  <= ~pin_r;
    end else begin
      half_r <= half_r + 16'h1;
    end
  end
endmodule : cts_buzzer

// *** rtl/cts_detect.sv ***
// one hysteresis touch detector for one sense input
`timescale 1ns/1ps
module cts_detect
  import cts_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  update,
  input  wire logic [CTS_TICK_W-1:0] ticks,
  input  wire logic [CTS_TICK_W-1:0] thresh,
  input  wire logic [CTS_TICK_W-1:0] hyst,
  output logic                       touched
);
  logic [CTS_TICK_W:0] on_lvl;
  logic [CTS_TICK_W:0] off_lvl;
  logic                touched_r;

  assign on_lvl  = {1'b0, thresh} + {1'b0, hyst};
  // clamp at zero so a large hysteresis cannot wrap
  assign off_lvl = (thresh > hyst) ? {1'b0, thresh - hyst} : '0;
  assign touched = touched_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      touched_r <= 1'b0;
    end else if (update) begin
      if (!touched_r && ({1'b0, ticks} >= on_lvl)) begin
        touched_r <= 1'b1;
      end else if (touched_r && ({1'b0, ticks} < off_lvl)) begin
        touched_r <= 1'b0;
      end
    end
  end
endmodule : cts_detect

// *** rtl/cts_pkg.sv ***
// constants and types shared by the touch scan controller
package cts_pkg;
  localparam int          CTS_CLK_HZ          = 100_000_000;
  localparam int          CTS_NUM_SENSE       = 8;
  localparam int          CTS_TICK_W          = 16;
  localparam int          CTS_PER_W           = 32;
  localparam int          CTS_MIN_PERIOD_MS   = 15;
  localparam int          CTS_ACTIVE_MS       = 30;
  localparam int          CTS_DOZE_MS         = 195;
  localparam int          CTS_BUZ_PHASE_MS    = 15;
  localparam int          CTS_BUZ_F1_HZ       = 4000;
  localparam int          CTS_BUZ_F2_HZ       = 8000;
  localparam int          CTS_PASSIVE_MS      = 5000;
  localparam int          CTS_CYC_PER_MS      = CTS_CLK_HZ / 1000;
  localparam logic [31:0] CTS_MIN_PERIOD_CYC  = 32'(CTS_MIN_PERIOD_MS * CTS_CYC_PER_MS);
  localparam logic [31:0] CTS_ACTIVE_CYC      = 32'(CTS_ACTIVE_MS * CTS_CYC_PER_MS);
  localparam logic [31:0] CTS_DOZE_CYC        = 32'(CTS_DOZE_MS * CTS_CYC_PER_MS);
  localparam logic [31:0] CTS_PASSIVE_CYC     = 32'(CTS_PASSIVE_MS * CTS_CYC_PER_MS);
  localparam logic [31:0] CTS_BUZ_PHASE_CYC   = 32'(CTS_BUZ_PHASE_MS * CTS_CYC_PER_MS);
  // half periods of the square wave
  localparam logic [15:0] CTS_BUZ_HALF1_CYC   = 16'(CTS_CLK_HZ / (2 * CTS_BUZ_F1_HZ));
  localparam logic [15:0] CTS_BUZ_HALF2_CYC   = 16'(CTS_CLK_HZ / (2 * CTS_BUZ_F2_HZ));
  localparam logic [15:0] CTS_THRESH_DEF      = 16'h0100;
  localparam logic [15:0] CTS_HYST_DEF        = 16'h0010;
  localparam logic [1:0]  CTS_MODE_AUTO       = 2'h0;
  localparam logic [1:0]  CTS_MODE_ACTIVE     = 2'h1;
  localparam logic [1:0]  CTS_MODE_DOZE       = 2'h2;
  localparam logic [1:0]  CTS_MODE_SLEEP      = 2'h3;

  typedef enum logic [2:0] {
    CTS_OP_ACTIVE = 3'b001,
    CTS_OP_DOZE   = 3'b010,
    CTS_OP_SLEEP  = 3'b100
  } cts_op_e;

  typedef enum logic [3:0] {
    CTS_PH_WAIT  = 4'b0001,
    CTS_PH_SENSE = 4'b0010,
    CTS_PH_GRAB  = 4'b0100,
    CTS_PH_PROC  = 4'b1000
  } cts_phase_e;
endpackage : cts_pkg

// *** rtl/cts_scan_ctrl.sv ***
// scan sequencer, mode control and result reporting of the touch controller
`timescale 1ns/1ps
module cts_scan_ctrl
  import cts_pkg::*;
#(
  parameter logic [31:0] ACTIVE_CYC  = CTS_ACTIVE_CYC,
  parameter logic [31:0] DOZE_CYC    = CTS_DOZE_CYC,
  parameter logic [31:0] PASSIVE_CYC = CTS_PASSIVE_CYC,
  parameter logic [31:0] BUZ_PH_CYC  = CTS_BUZ_PHASE_CYC,
  parameter logic [31:0] MIN_PER_CYC = CTS_MIN_PERIOD_CYC
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // analog front end: one conversion per request
  output logic                         sense_req,
  output logic [2:0]                   sense_sel,
  input  wire logic                    sense_done,
  input  wire logic [CTS_TICK_W-1:0]   sense_ticks,
  // stored parameters, applied once at boot
  input  wire logic                    param_store_valid,
  input  wire logic [7:0]              store_sense_enable,
  input  wire logic [CTS_TICK_W-1:0]   store_thresh,
  input  wire logic [CTS_TICK_W-1:0]   store_hyst,
  input  wire logic [31:0]             store_active_period,
  input  wire logic [31:0]             store_doze_period,
  // host side, already decoded from the serial bus
  input  wire logic                    host_access,
  input  wire logic                    host_status_read,
  input  wire logic                    host_wr_valid,
  input  wire logic [3:0]              host_wr_sel,
  input  wire logic [31:0]             host_wr_data,
  input  wire logic [2:0]              host_wr_chan,
  // results
  output logic [7:0]                   button_state,
  output logic                         prox_state,
  output logic [7:0]                   pin_out,
  output logic                         buzzer_pin,
  output logic                         host_alert_n,
  output logic [2:0]                   op_mode,
  output logic                         low_power
);
  // host write selectors
  localparam logic [3:0] WR_ENABLE   = 4'h0;
  localparam logic [3:0] WR_THRESH   = 4'h1;
  localparam logic [3:0] WR_HYST     = 4'h2;
  localparam logic [3:0] WR_ACT_PER  = 4'h3;
  localparam logic [3:0] WR_DOZE_PER = 4'h4;
  localparam logic [3:0] WR_PASSIVE  = 4'h5;
  localparam logic [3:0] WR_OPMODE   = 4'h6;
  localparam logic [3:0] WR_PROX     = 4'h7;
  localparam logic [3:0] WR_BUZ_CFG  = 4'h8;
  localparam logic [3:0] WR_BUZ_F    = 4'h9;
  localparam logic [3:0] WR_BUZ_D1   = 4'hA;
  localparam logic [3:0] WR_BUZ_D2   = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // parameter set
  logic [7:0]            sense_en_r;
  logic [CTS_TICK_W-1:0] thresh_r [CTS_NUM_SENSE];
  logic [CTS_TICK_W-1:0] hyst_r;
  logic [31:0]           act_per_r;
  logic [31:0]           doze_per_r;
  logic [31:0]           passive_r;
  logic [1:0]            mode_sel_r;
  logic                  prox_en_r;
  logic                  buz_en_r;
  logic                  buz_idle_r;
  logic [15:0]           buz_half1_r;
  logic [15:0]           buz_half2_r;
  logic [31:0]           buz_d1_r;
  logic [31:0]           buz_d2_r;
  logic                  booted_r;
  logic                  wr_param;

  assign wr_param = host_wr_valid && booted_r;

  // clamp so the period can never drop below the minimum
  function automatic logic [31:0] clamp_per(input logic [31:0] p);
    clamp_per = (p < MIN_PER_CYC) ? MIN_PER_CYC : p;
  endfunction : clamp_per

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      booted_r   <= 1'b0;
      sense_en_r <= 8'hFF;
      hyst_r     <= CTS_HYST_DEF;
      act_per_r  <= ACTIVE_CYC;
      doze_per_r <= DOZE_CYC;
      passive_r  <= PASSIVE_CYC;
      mode_sel_r <= CTS_MODE_AUTO;
      prox_en_r  <= 1'b0;
      buz_en_r   <= 1'b1;
      buz_idle_r <= 1'b0;
      buz_half1_r <= CTS_BUZ_HALF1_CYC;
      buz_half2_r <= CTS_BUZ_HALF2_CYC;
      buz_d1_r   <= BUZ_PH_CYC;
      buz_d2_r   <= BUZ_PH_CYC;
    end else if (!booted_r) begin
      booted_r <= 1'b1;
      if (param_store_valid) begin
        sense_en_r <= store_sense_enable;
        hyst_r     <= store_hyst;
        act_per_r  <= clamp_per(store_active_period);
        doze_per_r <= clamp_per(store_doze_period);
      end
    end else if (wr_param) begin
      unique case (host_wr_sel)
        WR_ENABLE:   sense_en_r <= host_wr_data[7:0];
        WR_HYST:     hyst_r     <= host_wr_data[CTS_TICK_W-1:0];
        WR_ACT_PER:  act_per_r  <= clamp_per(host_wr_data);
        WR_DOZE_PER: doze_per_r <= clamp_per(host_wr_data);
        WR_PASSIVE:  passive_r  <= host_wr_data;
        WR_OPMODE:   mode_sel_r <= host_wr_data[1:0];
        WR_PROX:     prox_en_r  <= host_wr_data[0];
        WR_BUZ_CFG: begin
          buz_en_r   <= host_wr_data[0];
          buz_idle_r <= host_wr_data[1];
        end
        WR_BUZ_F: begin
          buz_half1_r <= host_wr_data[15:0];
          buz_half2_r <= host_wr_data[31:16];
        end
        WR_BUZ_D1:   buz_d1_r <= host_wr_data;
        WR_BUZ_D2:   buz_d2_r <= host_wr_data;
        default:     ;
      endcase
    end
  end

  // thresholds are per sensor; all start from one stored value
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CTS_NUM_SENSE; i++) begin
      if (srst) begin
        thresh_r[i] <= CTS_THRESH_DEF;
      end else if (!booted_r && param_store_valid) begin
        thresh_r[i] <= store_thresh;
      end else if (wr_param && host_wr_sel == WR_THRESH && host_wr_chan == 3'(i)) begin
        thresh_r[i] <= host_wr_data[CTS_TICK_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode
  cts_op_e     op_r;
  logic [31:0] idle_cnt_r;
  logic        any_touch;
  logic        proc_pulse;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_r <= CTS_OP_ACTIVE;
    end else if (mode_sel_r == CTS_MODE_ACTIVE) begin
      op_r <= CTS_OP_ACTIVE;
    end else if (mode_sel_r == CTS_MODE_DOZE) begin
      op_r <= CTS_OP_DOZE;
    end else if (mode_sel_r == CTS_MODE_SLEEP && !host_access) begin
      op_r <= CTS_OP_SLEEP;
    end else begin
      unique case (op_r)
        CTS_OP_SLEEP:  op_r <= CTS_OP_ACTIVE;
        CTS_OP_DOZE:   if (proc_pulse && any_touch) op_r <= CTS_OP_ACTIVE;
        CTS_OP_ACTIVE: if (passive_r != '0 && idle_cnt_r >= passive_r) op_r <= CTS_OP_DOZE;
      endcase
    end
  end

  // inactivity counter; zero setting disables the move to doze
  always_ff @(posedge ref_clk) begin
    if (srst || any_touch || host_access || op_r != CTS_OP_ACTIVE) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != 32'hFFFF_FFFF) begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer
  cts_phase_e           ph_r;
  logic [31:0]          per_cnt_r;
  logic [2:0]           chan_r;
  logic [CTS_TICK_W-1:0] samp_r [CTS_NUM_SENSE];
  logic [31:0]          cur_per;
  logic                 per_done;
  logic                 last_en;
  logic                 req_r;

  assign cur_per  = (op_r == CTS_OP_DOZE) ? doze_per_r : act_per_r;
  assign per_done = (per_cnt_r + 32'h1) >= cur_per;
  // no enabled channel above the current one
  assign last_en  = ((sense_en_r >> chan_r) >> 1) == 8'h00;
  assign proc_pulse = (ph_r == CTS_PH_PROC);

  // period timer runs free so sense time is part of the period
  always_ff @(posedge ref_clk) begin
    if (srst || op_r == CTS_OP_SLEEP || per_done) begin
      per_cnt_r <= '0;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_r   <= CTS_PH_WAIT;
      chan_r <= '0;
      req_r  <= 1'b0;
    end else begin
      unique case (ph_r)
        CTS_PH_WAIT: begin
          req_r <= 1'b0;
          if (per_done && op_r != CTS_OP_SLEEP) begin
            ph_r   <= (sense_en_r == 8'h00) ? CTS_PH_PROC : CTS_PH_SENSE;
            chan_r <= '0;
          end
        end
        CTS_PH_SENSE: begin
          if (op_r == CTS_OP_SLEEP) begin
            ph_r <= CTS_PH_WAIT;
          end else if (!sense_en_r[chan_r]) begin
            chan_r <= chan_r + 3'h1;
          end else if (!req_r) begin
            req_r <= 1'b1;
          end else if (sense_done) begin
            req_r <= 1'b0;
            ph_r  <= CTS_PH_GRAB;
          end
        end
        CTS_PH_GRAB: begin
          if (last_en) begin
            ph_r <= CTS_PH_PROC;
          end else begin
            chan_r <= chan_r + 3'h1;
            ph_r   <= CTS_PH_SENSE;
          end
        end
        CTS_PH_PROC: ph_r <= CTS_PH_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CTS_NUM_SENSE; i++) begin
      if (srst) begin
        samp_r[i] <= '0;
      end else if (ph_r == CTS_PH_SENSE && req_r && sense_done && chan_r == 3'(i)) begin
        samp_r[i] <= sense_ticks;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sense_req <= 1'b0;
      sense_sel <= '0;
      low_power <= 1'b1;
      op_mode   <= CTS_OP_ACTIVE;
    end else begin
      sense_req <= (ph_r == CTS_PH_SENSE) && sense_en_r[chan_r] && !req_r;
      sense_sel <= chan_r;
      low_power <= (ph_r == CTS_PH_WAIT);
      op_mode   <= op_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection and reporting
  logic [7:0] det;
  logic [7:0] btn_mask;
  logic       buz_start_r;

  genvar g;
  generate
    for (g = 0; g < CTS_NUM_SENSE; g++) begin : g_det
      cts_detect u_det (
        .ref_clk (ref_clk),
        .srst    (srst),
        .update  (proc_pulse && sense_en_r[g]),
        .ticks   (samp_r[g]),
        .thresh  (thresh_r[g]),
        .hyst    (hyst_r),
        .touched (det[g])
      );
    end
  endgenerate

  // input 0 reports as proximity instead of a button when selected
  assign btn_mask  = prox_en_r ? 8'hFE : 8'hFF;
  assign any_touch = |(det & btn_mask & sense_en_r);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      button_state <= '0;
      prox_state   <= 1'b0;
      pin_out      <= '0;
      buz_start_r  <= 1'b0;
    end else begin
      buz_start_r <= 1'b0;
      if (ph_r == CTS_PH_WAIT && per_done && op_r != CTS_OP_SLEEP) begin
        button_state <= det & btn_mask & sense_en_r;
        prox_state   <= prox_en_r && det[0] && sense_en_r[0];
        pin_out      <= det & btn_mask & sense_en_r;
        // buzz only on a new press, not on a held one
        buz_start_r  <= |((det & btn_mask & sense_en_r) & ~button_state);
      end
    end
  end

  // alert: set on changed results, cleared by a status read; set wins
  logic [7:0] prev_rep_r;
  logic       prev_prox_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_rep_r   <= '0;
      prev_prox_r  <= 1'b0;
      host_alert_n <= 1'b1;
    end else begin
      prev_rep_r  <= button_state;
      prev_prox_r <= prox_state;
      if (prev_rep_r != button_state || prev_prox_r != prox_state) begin
        host_alert_n <= 1'b0;
      end else if (host_status_read) begin
        host_alert_n <= 1'b1;
      end
    end
  end

  cts_buzzer u_buz (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .start      (buz_start_r),
    .enable     (buz_en_r),
    .idle_level (buz_idle_r),
    .half1_cyc  (buz_half1_r),
    .half2_cyc  (buz_half2_r),
    .phase1_cyc (buz_d1_r),
    .phase2_cyc (buz_d2_r),
    .pin        (buzzer_pin),
    .busy       ()
  );
endmodule : cts_scan_ctrl

// *** testbench/cts_afe_model.sv ***
// front end model: answers each conversion request after a set delay
`timescale 1ns/1ps
module cts_afe_model
  import cts_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sense_req,
  input  wire logic [2:0]            sense_sel,
  input  wire logic [127:0]          tick_tab,
  input  wire logic [3:0]            delay,
  output logic                       sense_done,
  output logic [CTS_TICK_W-1:0]      sense_ticks
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] ch_r  = 3'h0;
  initial begin
    sense_done  = 1'b0;
    sense_ticks = 16'h0000;
  end
  always @(posedge ref_clk) begin
    sense_done  <= 1'b0;
    // ticks are only valid with done, so they are inverted every cycle
    sense_ticks <= ~sense_ticks;
    if (sense_req) begin
      ch_r  <= sense_sel;
      cnt_r <= delay;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        sense_done  <= 1'b1;
        sense_ticks <= tick_tab[ch_r*16 +: 16];
      end
    end
  end
endmodule : cts_afe_model

// *** testbench/cts_scan_properties.sv ***
// port assertions for the scan controller
`timescale 1ns/1ps
module cts_scan_chk
  import cts_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       sense_req,
  input wire logic [2:0] sense_sel,
  input wire logic       sense_done,
  input wire logic       host_access,
  input wire logic       host_status_read,
  input wire logic [7:0] button_state,
  input wire logic       prox_state,
  input wire logic [7:0] pin_out,
  input wire logic       host_alert_n,
  input wire logic [2:0] op_mode,
  input wire logic       low_power
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [2:0] last_sel_r;
  logic       fresh_r;
  // a new scan may start anywhere, later requests must climb
  always_ff @(posedge ref_clk) begin
    if (srst || low_power) begin
      fresh_r <= 1'b1;
    end else if (sense_req) begin
      fresh_r <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sense_req) begin
      last_sel_r <= sense_sel;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_new_result;
    $changed({prox_state, button_state});
  endsequence
  sequence s_quiet_read;
    host_status_read && $stable({prox_state, button_state});
  endsequence
  sequence s_asleep;
    op_mode == CTS_OP_SLEEP [*2];
  endsequence
  property p_order; sense_req |-> fresh_r || sense_sel > last_sel_r; endproperty
  a_order: assert property (p_order) else $error("channels out of order");
  property p_one_out; sense_req |=> !sense_req until_with sense_done; endproperty
  a_one_out: assert property (p_one_out) else $error("second request outstanding");
  property p_wait_quiet; low_power |-> !sense_req; endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("request in wait phase");
  property p_update_win; !$stable(button_state) |-> $past(low_power); endproperty
  a_update_win: assert property (p_update_win) else $error("results moved outside update");
  property p_alert_set; s_new_result |=> !host_alert_n; endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert missing after change");
  property p_alert_hold; !host_alert_n && !host_status_read |=> !host_alert_n; endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped unread");
  property p_alert_clear; s_quiet_read |=> host_alert_n; endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert not cleared by read");
  property p_pins; pin_out == button_state; endproperty
  a_pins: assert property (p_pins) else $error("pins differ from buttons");
  property p_sleep_idle; s_asleep |-> !sense_req; endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("scan while asleep");
  property p_wake; host_access && op_mode == CTS_OP_SLEEP |-> ##[0:2] op_mode == CTS_OP_ACTIVE; endproperty
  a_wake: assert property (p_wake) else $error("host access did not wake");
endmodule : cts_scan_chk

bind cts_scan_ctrl cts_scan_chk chk_u (
  .ref_clk(ref_clk), .srst(srst), .sense_req(sense_req), .sense_sel(sense_sel),
  .sense_done(sense_done), .host_access(host_access), .host_status_read(host_status_read),
  .button_state(button_state), .prox_state(prox_state), .pin_out(pin_out),
  .host_alert_n(host_alert_n), .op_mode(op_mode), .low_power(low_power)
);

// *** testbench/tb.sv ***
// self-checking bench for the touch scan controller
`timescale 1ns/1ps
module tb
  import cts_pkg::*;
;
  localparam logic [31:0] ACT_CYC = 32'h0000_00C8;
  logic         ref_clk = 1'b0;
  logic         srst = 1'b1;
  logic         param_store_valid = 1'b0;
  logic         host_access = 1'b0;
  logic         host_status_read = 1'b0;
  logic         host_wr_valid = 1'b0;
  logic [3:0]   host_wr_sel = 4'h0;
  logic [31:0]  host_wr_data = 32'h0;
  logic [2:0]   host_wr_chan = 3'h0;
  logic [127:0] tick_tab = 128'h0;
  logic [3:0]   afe_delay = 4'h2;
  logic [7:0]   st_en = 8'hFF;
  logic [15:0]  st_hy = 16'h0010;
  logic [31:0]  st_ap = 32'h0000_0096, st_dz = 32'h0000_0190;
  logic         sense_req, sense_done, prox_state, buzzer_pin, host_alert_n, low_power;
  logic [2:0]   sense_sel, op_mode;
  logic [7:0]   button_state, pin_out;
  logic [15:0]  sense_ticks;
  logic [2:0]   log_q[$];
  int           bad_count = 0;
  int           n_compared = 0;
  int           cyc = 0;
  int           edges;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sense_req === 1'b1) begin
      log_q.push_back(sense_sel);
    end
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  cts_afe_model afe_u (.ref_clk(ref_clk), .sense_req(sense_req), .sense_sel(sense_sel),
    .tick_tab(tick_tab), .delay(afe_delay), .sense_done(sense_done), .sense_ticks(sense_ticks));
  cts_scan_ctrl #(.ACTIVE_CYC(ACT_CYC), .DOZE_CYC(32'h0000_0190), .PASSIVE_CYC(32'h0000_07D0),
    .BUZ_PH_CYC(32'h0000_0064), .MIN_PER_CYC(32'h0000_0032)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .sense_req(sense_req), .sense_sel(sense_sel),
    .sense_done(sense_done), .sense_ticks(sense_ticks), .param_store_valid(param_store_valid),
    .store_sense_enable(st_en), .store_thresh(16'h0200), .store_hyst(st_hy),
    .store_active_period(st_ap), .store_doze_period(st_dz),
    .host_access(host_access), .host_status_read(host_status_read), .host_wr_valid(host_wr_valid),
    .host_wr_sel(host_wr_sel), .host_wr_data(host_wr_data), .host_wr_chan(host_wr_chan),
    .button_state(button_state), .prox_state(prox_state), .pin_out(pin_out),
    .buzzer_pin(buzzer_pin), .host_alert_n(host_alert_n), .op_mode(op_mode), .low_power(low_power));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] sel, input logic [31:0] d, input logic [2:0] ch = 3'h0);
    @(posedge ref_clk);
    host_wr_valid <= 1'b1;
    host_wr_sel   <= sel;
    host_wr_data  <= d;
    host_wr_chan  <= ch;
    @(posedge ref_clk);
    host_wr_valid <= 1'b0;
  endtask : wr
  // sets one channel's ticks and counts buzzer edges while results settle
  task automatic touch(input int ch, input logic [15:0] v, input int n = 700);
    logic prev;
    @(posedge ref_clk);
    tick_tab[ch*16 +: 16] <= v;
    edges = 0;
    #1;
    prev = buzzer_pin;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      edges += int'(buzzer_pin !== prev);
      prev = buzzer_pin;
    end
  endtask : touch
  task automatic rd_status;
    @(posedge ref_clk);
    host_status_read <= 1'b1;
    @(posedge ref_clk);
    host_status_read <= 1'b0;
    #1;
    chk("alert after read", 32'h1, 32'(host_alert_n));
  endtask : rd_status
  task automatic wait_lp(input logic v);
    for (int i = 0; i < 3000 && low_power !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : wait_lp
  task automatic scan_gap(output int g);
    int t0;
    wait_lp(1'b1);
    wait_lp(1'b0);
    t0 = cyc;
    wait_lp(1'b1);
    wait_lp(1'b0);
    g = cyc - t0;
  endtask : scan_gap
  ////////////////////////////////////////////////////////////
  task automatic t_boot_hyst;
    int g;
    scan_gap(g);
    chk("stored period", 32'h96, 32'(g));
    touch(1, 16'h020F);
    chk("under touch level", 32'h0, 32'(button_state));
    touch(1, 16'h0210);
    chk("touch level", 32'h2, 32'(button_state));
    chk("alert on touch", 32'h0, 32'(host_alert_n));
    rd_status();
    wr(4'h1, 32'h0000_0100, 3'h1);
    touch(1, 16'h00F0);
    chk("held in band", 32'h2, 32'(button_state));
    touch(1, 16'h00EF);
    chk("release", 32'h0, 32'(button_state));
    rd_status();
  endtask : t_boot_hyst
  task automatic t_order;
    afe_delay <= 4'h9;
    wr(4'h0, 32'h0000_00A5);
    touch(0, 16'h0000);
    wait_lp(1'b1);
    wait_lp(1'b0);
    log_q.delete();
    wait_lp(1'b1);
    chk("scan count", 32'h4, 32'(log_q.size()));
    chk("scan order", 32'h0AF, 32'({log_q[0], log_q[1], log_q[2], log_q[3]}));
    afe_delay <= 4'h2;
    wr(4'h0, 32'h0000_00FF);
  endtask : t_order
  task automatic t_period;
    int g;
    wr(4'h3, 32'h0000_000A);
    scan_gap(g);
    scan_gap(g);
    chk("clamped period", 32'h32, 32'(g));
    wr(4'h3, 32'h0000_012C);
    scan_gap(g);
    scan_gap(g);
    chk("host period", 32'h12C, 32'(g));
    wr(4'h3, ACT_CYC);
    wr(4'h6, 32'h2);
    scan_gap(g);
    scan_gap(g);
    chk("doze period", 32'h190, 32'(g));
    chk("forced doze", 32'(CTS_OP_DOZE), 32'(op_mode));
    wr(4'h6, 32'h1);
  endtask : t_period
  task automatic t_buzz;
    wr(4'h9, 32'h0003_0005);
    wr(4'hA, 32'h64);
    wr(4'hB, 32'h64);
    wr(4'h8, 32'h1);
    touch(3, 16'h0300, 1200);
    // 100 cycles at half period 5, then 100 at half period 3
    chk("tone edges", 32'h1, 32'(edges >= 51 && edges <= 55));
    touch(3, 16'h0000);
    rd_status();
    wr(4'h8, 32'h2);
    touch(3, 16'h0300);
    chk("idle level", 32'h1, 32'(buzzer_pin));
    chk("muted edges", 32'h0, 32'(edges));
    touch(3, 16'h0000);
    rd_status();
  endtask : t_buzz
  task automatic t_prox;
    wr(4'h7, 32'h1);
    touch(0, 16'h0300);
    chk("proximity", 32'h1, 32'(prox_state));
    chk("prox not a button", 32'h0, 32'(button_state));
    touch(0, 16'h0000);
    chk("proximity gone", 32'h0, 32'(prox_state));
    rd_status();
    wr(4'h7, 32'h0);
  endtask : t_prox
  task automatic t_modes;
    logic woke;
    wr(4'h6, 32'h0);
    touch(0, 16'h0000, 2500);
    chk("timer off", 32'(CTS_OP_ACTIVE), 32'(op_mode));
    wr(4'h5, 32'h12C);
    for (int i = 0; i < 1500 && op_mode !== CTS_OP_DOZE; i++) @(posedge ref_clk);
    chk("to doze", 32'(CTS_OP_DOZE), 32'(op_mode));
    @(posedge ref_clk);
    tick_tab[47:32] <= 16'h0300;
    for (int i = 0; i < 1500 && op_mode !== CTS_OP_ACTIVE; i++) @(posedge ref_clk);
    chk("touch wakes", 32'(CTS_OP_ACTIVE), 32'(op_mode));
    touch(2, 16'h0000);
    rd_status();
    wr(4'h6, 32'h3);
    touch(0, 16'h0000, 3);
    log_q.delete();
    touch(0, 16'h0000, 1000);
    chk("sleep scans", 32'h0, 32'(log_q.size()));
    chk("forced sleep", 32'(CTS_OP_SLEEP), 32'(op_mode));
    host_access <= 1'b1;
    @(posedge ref_clk);
    host_access <= 1'b0;
    woke = 1'b0;
    repeat (3) begin
      #1;
      woke |= (op_mode === CTS_OP_ACTIVE);
      @(posedge ref_clk);
    end
    chk("host wakes", 32'h1, 32'(woke));
    wr(4'h6, 32'h0);
  endtask : t_modes
  task automatic t_reboot;
    srst  <= 1'b1;
    st_en <= 8'hFE;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    touch(0, 16'h0300);
    chk("stored enables", 32'h0, 32'(button_state));
  endtask : t_reboot

  initial begin
    param_store_valid = 1'b1;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    touch(0, 16'h0000, 3);
    wr(4'h5, 32'h0);
    t_boot_hyst();
    t_order();
    t_period();
    t_buzz();
    t_prox();
    t_modes();
    t_reboot();
    close_out();
  end
endmodule : tb
